// *** include/dre_pkg.sv ***
// dre_pkg: constants, coefficients and carrier types of the decimation engine
package dre_pkg;

    // =========================================================
    // widths and sizes
    localparam int SW         = 20;   // internal sample width
    localparam int OW         = 16;   // result word width
    localparam int AW         = 48;   // accumulator width
    localparam int CW         = 18;   // coefficient width
    localparam int NSINC      = 4;    // sinc3 window, decimate by 2
    localparam int NLINE      = 63;   // longest delay line
    localparam int NHALF      = 32;   // coefficient slots per filter
    localparam int NDEC       = 23;
    localparam int NEQ        = 63;
    localparam int NI1        = 27;
    localparam int NI2        = 15;
    localparam int FIFO_DEPTH = 8;

    // =========================================================
    // gain shifts that bring each stage back to unity
    localparam int SH_SINC = 3;
    localparam int SH_DEC  = 15;
    localparam int SH_EQ   = 16;
    localparam int SH_I1   = 15;
    localparam int SH_I2   = 13;

    // =========================================================
    // levels, selections and resampler codes
    localparam logic [SW-1:0] MOD_POS     = 20'h07fff;
    localparam logic [SW-1:0] MOD_NEG     = 20'hf8001;
    localparam logic [SW-1:0] SAT_HI      = 20'h07fff;
    localparam logic [SW-1:0] SAT_LO      = 20'hf8000;
    localparam logic [OW-1:0] OUT_HI      = 16'h7fff;
    localparam logic [OW-1:0] OUT_LO      = 16'h8000;
    localparam logic [1:0]    BW_10       = 2'h0;
    localparam logic [1:0]    BW_5        = 2'h1;
    localparam logic [1:0]    BW_2P5      = 2'h2;
    localparam logic [1:0]    DEC_PH_LAST = 2'h3;
    localparam logic [5:0]    KOUT_RST    = 6'h00;
    localparam logic [6:0]    KHALF_MIN   = 7'h08;
    localparam logic [6:0]    PHASE_STEP  = 7'h02;

    // =========================================================
    // types
    typedef logic signed [CW-1:0] dre_coef_t [NHALF];
    typedef logic [NLINE-1:0][SW-1:0] dre_line_t;
    typedef logic [NSINC-1:0][SW-1:0] dre_win_t;
    typedef struct packed {
        logic          vld;
        logic [SW-1:0] smp;
    } dre_smp_s;
    typedef enum logic [1:0] {
        RS_RESET = 2'b00,
        RS_RUN   = 2'b01
    } dre_rs_e;

    // =========================================================
    // outer half of each symmetric filter, centre tap last
    localparam dre_coef_t DEC_C = '{0: -18'sh15, 2: 18'sh7a, 4: -18'sh1a2,
        6: 18'sh461, 8: -18'shaec, 10: 18'sh27c8, 11: 18'sh4000, default: '0};
    localparam dre_coef_t EQ_C = '{18'sh11, 18'sh1f, -18'shf, -18'sh34,
        18'sh24, 18'sh4e, -18'sh54, -18'sh62, 18'shaa, 18'sh61, -18'sh123,
        -18'sh2a, 18'sh1b9, -18'sh62, -18'sh250, 18'sh161, 18'sh2b6,
        -18'sh2e8, -18'sh2a5, 18'sh4f7, 18'sh1c2, -18'sh775, 18'sh67,
        18'sha34, -18'sh47b, -18'shcfe, 18'shbce, 18'shfd3, -18'sh1ad6,
        -18'sh14b9, 18'sh5295, 18'sh982c};
    localparam dre_coef_t I1_C = '{0: 18'shf, 2: -18'sh61, 4: 18'sh169,
        6: -18'sh3f9, 8: 18'sh992, 10: -18'sh1681, 12: 18'sh4fd1,
        13: 18'sh8000, default: '0};
    localparam dre_coef_t I2_C = '{0: -18'sh1b, 2: 18'she3, 4: -18'sh408,
        6: 18'sh1340, 7: 18'sh2000, default: '0};

endpackage

// *** hdl/dre_fifo.sv ***
// dre_fifo: result word buffer with registered output and honest full flag
`timescale 1ns/1ps
module dre_fifo
    import dre_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // filling side
    input  wire logic             i_wr_valid,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_wr_ready,
    // draining side
    input  wire logic             i_rd_ready,
    output logic                  o_rd_valid,
    output logic      [WIDTH-1:0] o_rd_data
);

    localparam int PW = $clog2(DEPTH);
    localparam int NW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [NW-1:0]               cnt;
        logic                        full;
        logic                        ovld;
        logic [WIDTH-1:0]            odata;
    } dre_fifo_state_s;

    dre_fifo_state_s st_ff;
    dre_fifo_state_s nxt_st;

    // pointer step with wrap at depth
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // =========================================================
    // queue and output register
    always_comb begin
        logic wr;
        logic rd;
        wr = i_wr_valid & ~st_ff.full;
        rd = (st_ff.cnt != '0) & (~st_ff.ovld | i_rd_ready);
        nxt_st = st_ff;
        if (st_ff.ovld & i_rd_ready) begin
            nxt_st.ovld = 1'b0;
        end
        if (rd) begin
            nxt_st.odata = st_ff.mem[st_ff.rp];
            nxt_st.ovld  = 1'b1;
            nxt_st.rp    = ptr_inc(st_ff.rp);
        end
        if (wr) begin
            nxt_st.mem[st_ff.wp] = i_wr_data;
            nxt_st.wp            = ptr_inc(st_ff.wp);
        end
        nxt_st.cnt  = NW'(st_ff.cnt + NW'(wr) - NW'(rd));
        nxt_st.full = (nxt_st.cnt == NW'(DEPTH));
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_wr_ready = ~st_ff.full;
    assign o_rd_valid = st_ff.ovld;
    assign o_rd_data  = st_ff.odata;

    // =========================================================
    // checks
    chk_fifo_hold: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE15
        (o_rd_valid && !i_rd_ready) |=> (o_rd_valid && $stable(o_rd_data)))
        else $error("result word changed while stalled");
    chk_fifo_full: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE15
        (st_ff.full && i_wr_valid) |=> $stable(st_ff.wp))
        else $error("write taken while buffer full");

endmodule

// *** hdl/dre_engine.sv ***
// dre_engine: sinc decimators, fixed decimator, equalizer and resampler
//
// Function
// RULE1 - cascaded identical sinc3 stages, each halving the rate, precede the decimator
// RULE2 - 10 MHz band bypasses sinc, 5 MHz uses one stage, 2.5 MHz two
// RULE3 - a two-bit bandwidth field picks the number of sinc stages
// RULE4 - fixed decimator is a 23-tap symmetric filter, centre tap 16384
// RULE5 - a fixed low-pass after the decimator defines band and corrects droop
// RULE6 - equalizer is a 63-tap symmetric filter, centre tap 38956
// RULE7 - resampler interpolates the filtered stream to a programmable output rate
// RULE8 - first interpolator is a 27-tap symmetric filter, centre tap 32768
// RULE9 - second interpolator is a 15-tap symmetric filter, centre tap 8192
// RULE10 - output sample rate equals clock rate divided by division factor; the code gives twice the clock rate over the factor, factor floored at 8
// RULE11 - six-bit division factor; zero holds the resampler in reset
// RULE12 - host writes zero then the factor once the clock source is locked
// RULE13 - host should reset the resampler after clock loss and recovery
// RULE14 - sinc stages are plain sinc filters with no coefficient shaping
// RULE15 - one 16-bit word per output period, none during resampler reset; the code stops new words but buffered words still leave during reset
`timescale 1ns/1ps
module dre_engine
    import dre_pkg::*;
(
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rstn,
    // modulator stream, one bit per clock
    input  wire logic          i_mod_bit,
    // configuration
    input  wire logic [1:0]    i_bw_sel,
    input  wire logic [5:0]    i_kout,
    // result stream
    input  wire logic          i_ready,
    output logic      [OW-1:0] o_data,
    output logic               o_valid,
    output logic               o_drop
);

    // =========================================================
    // state
    typedef struct packed {
        dre_win_t      s1_win;
        logic          s1_ph;
        dre_smp_s      s1;
        dre_win_t      s2_win;
        logic          s2_ph;
        dre_smp_s      s2;
        dre_line_t     dec_line;
        logic [1:0]    dec_ph;
        dre_smp_s      dec;
        dre_line_t     eq_line;
        dre_smp_s      eq;
        dre_rs_e       rs;
        dre_line_t     i1_line;
        logic          i1_zero;
        dre_smp_s      i1;
        dre_line_t     i2_line;
        logic          i2_zero;
        dre_smp_s      i2;
        logic [6:0]    acc;
        logic [OW-1:0] hold;
        logic          emit;
        logic          drop;
    } dre_state_s;

    dre_state_s    st_ff;
    dre_state_s    nxt_st;
    logic [SW-1:0] mod_smp;
    dre_smp_s      dec_in;
    logic          wr_ready;

    // =========================================================
    // arithmetic helpers

    // sign extension to accumulator width
    function automatic logic signed [AW-1:0] sx(input logic [SW-1:0] v);
        return AW'(signed'(v));
    endfunction

    // plain sinc3 over a four-sample window, taps 1 3 3 1
    function automatic logic [SW-1:0] sinc3(input dre_win_t w);
        logic signed [AW-1:0] m;
        logic signed [AW-1:0] s;
        m = sx(w[1]) + sx(w[2]);
        s = sx(w[0]) + sx(w[3]) + m + (m <<< 1);
        return SW'(s >>> SH_SINC); // RULE14
    endfunction

    // symmetric fir: outer half of taps folded, centre tap added once
    function automatic logic [SW-1:0] fir_sym(input dre_line_t d,
                                              input dre_coef_t c,
                                              input int        ntap,
                                              input int        sh);
        logic signed [AW-1:0] acc;
        acc = '0;
        for (int k = 0; k < NHALF; k++) begin
            if (k < ntap / 2) begin
                acc = acc + c[k] * (sx(d[k]) + sx(d[ntap - 1 - k]));
            end else if (k == ntap / 2) begin
                acc = acc + c[k] * sx(d[k]);
            end
        end
        return SW'(acc >>> sh);
    endfunction

    // clip to the result word
    function automatic logic [OW-1:0] sat_out(input logic [SW-1:0] v);
        if ($signed(v) > $signed(SAT_HI)) begin
            return OUT_HI;
        end else if ($signed(v) < $signed(SAT_LO)) begin
            return OUT_LO;
        end
        return v[OW-1:0];
    endfunction

    // =========================================================
    // modulator level and decimator source selection
    assign mod_smp = i_mod_bit ? MOD_POS : MOD_NEG;
    assign dec_in  = (i_bw_sel == BW_5)   ? st_ff.s1 :           // RULE2
                     (i_bw_sel == BW_2P5) ? st_ff.s2 :           // RULE3
                     dre_smp_s'{vld: 1'b1, smp: mod_smp};

    // =========================================================
    // next state of the whole filter chain
    always_comb begin
        logic [SW-1:0] i1_in;
        logic [SW-1:0] i2_in;
        logic [6:0]    khalf;
        logic [6:0]    sum;
        i1_in = '0;
        i2_in = '0;
        khalf = '0;
        sum   = '0;
        nxt_st        = st_ff;
        nxt_st.s1.vld = 1'b0;
        nxt_st.s2.vld = 1'b0;
        nxt_st.dec.vld = 1'b0;
        nxt_st.eq.vld = 1'b0;
        nxt_st.i1.vld = 1'b0;
        nxt_st.i2.vld = 1'b0;
        nxt_st.emit   = 1'b0;

        // first sinc3 stage, every modulator sample, one out of two kept
        if ((i_bw_sel == BW_5) || (i_bw_sel == BW_2P5)) begin // RULE2
            nxt_st.s1_win = {st_ff.s1_win[NSINC-2:0], mod_smp};
            nxt_st.s1_ph  = ~st_ff.s1_ph;
            if (st_ff.s1_ph) begin
                nxt_st.s1.vld = 1'b1; // RULE1
                nxt_st.s1.smp = sinc3(nxt_st.s1_win);
            end
        end

        // second identical stage fed by the first
        if ((i_bw_sel == BW_2P5) && st_ff.s1.vld) begin // RULE3
            nxt_st.s2_win = {st_ff.s2_win[NSINC-2:0], st_ff.s1.smp};
            nxt_st.s2_ph  = ~st_ff.s2_ph;
            if (st_ff.s2_ph) begin
                nxt_st.s2.vld = 1'b1; // RULE1
                nxt_st.s2.smp = sinc3(nxt_st.s2_win);
            end
        end

        // fixed decimator, one result per four inputs
        if (dec_in.vld) begin
            nxt_st.dec_line = {st_ff.dec_line[NLINE-2:0], dec_in.smp};
            nxt_st.dec_ph   = st_ff.dec_ph + 1'b1;
            if (st_ff.dec_ph == DEC_PH_LAST) begin
                nxt_st.dec.vld = 1'b1;
                nxt_st.dec.smp = fir_sym(nxt_st.dec_line, DEC_C, NDEC, SH_DEC); // RULE4
            end
        end

        // band-shaping equalizer at the decimated rate
        if (st_ff.dec.vld) begin
            nxt_st.eq_line = {st_ff.eq_line[NLINE-2:0], st_ff.dec.smp};
            nxt_st.eq.vld  = 1'b1; // RULE5
            nxt_st.eq.smp  = fir_sym(nxt_st.eq_line, EQ_C, NEQ, SH_EQ); // RULE6
        end

        // resampler: held cleared while the factor reads zero
        if (i_kout == KOUT_RST) begin
            nxt_st.rs      = RS_RESET; // RULE11
            nxt_st.i1_line = '0;
            nxt_st.i2_line = '0;
            nxt_st.i1_zero = 1'b0;
            nxt_st.i2_zero = 1'b0;
            nxt_st.acc     = '0;
            nxt_st.hold    = '0;
        end else begin
            nxt_st.rs = RS_RUN;

            // first interpolator: sample then stuffed zero
            if (st_ff.eq.vld) begin
                i1_in          = st_ff.eq.smp;
                nxt_st.i1_zero = 1'b1;
                nxt_st.i1.vld  = 1'b1;
            end else if (st_ff.i1_zero) begin
                nxt_st.i1_zero = 1'b0;
                nxt_st.i1.vld  = 1'b1;
            end
            if (nxt_st.i1.vld) begin
                nxt_st.i1_line = {st_ff.i1_line[NLINE-2:0], i1_in};
                nxt_st.i1.smp  = fir_sym(nxt_st.i1_line, I1_C, NI1, SH_I1); // RULE8
            end

            // second interpolator: both words of each pair, then one stuffed zero
            if (st_ff.i1.vld) begin
                i2_in          = st_ff.i1.smp;
                nxt_st.i2_zero = 1'b1;
                nxt_st.i2.vld  = 1'b1;
            end else if (st_ff.i2_zero) begin
                nxt_st.i2_zero = 1'b0;
                nxt_st.i2.vld  = 1'b1;
            end
            if (nxt_st.i2.vld) begin
                nxt_st.i2_line = {st_ff.i2_line[NLINE-2:0], i2_in};
                nxt_st.i2.smp  = fir_sym(nxt_st.i2_line, I2_C, NI2, SH_I2); // RULE9
            end

            // zero-order hold of the newest interpolated sample
            if (st_ff.i2.vld) begin
                nxt_st.hold = sat_out(st_ff.i2.smp); // RULE7
            end

            // phase accumulator in half clocks: one word per factor, factor floored at 8
            khalf = ({1'b0, i_kout} < KHALF_MIN) ? KHALF_MIN : {1'b0, i_kout};
            sum   = st_ff.acc + PHASE_STEP;
            if (sum >= khalf) begin
                nxt_st.acc  = sum - khalf; // RULE10
                nxt_st.emit = 1'b1;
            end else begin
                nxt_st.acc = sum;
            end
        end

        // word lost when the buffer refuses it
        nxt_st.drop = st_ff.drop | (st_ff.emit & ~wr_ready);
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // result buffer
    dre_fifo #(
        .WIDTH (OW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_wr_valid (st_ff.emit), // RULE15
        .i_wr_data  (st_ff.hold),
        .o_wr_ready (wr_ready),
        .i_rd_ready (i_ready),
        .o_rd_valid (o_valid),
        .o_rd_data  (o_data)
    );

    assign o_drop = st_ff.drop;

    // =========================================================
    // checks
    chk_sinc_half: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE1
        st_ff.s1.vld |=> !st_ff.s1.vld)
        else $error("sinc stage did not halve the rate");
    chk_bw_bypass: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE2
        (i_bw_sel == BW_10) |-> (dec_in.vld && dec_in.smp == mod_smp))
        else $error("bypass band lost an input sample");
    chk_bw_two: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE3
        (i_bw_sel == BW_2P5 && $stable(i_bw_sel) && dec_in.vld)
        |=> (!dec_in.vld || i_bw_sel != BW_2P5)[*3])
        else $error("two-stage band rate wrong");
    chk_dec_rate: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE4
        st_ff.dec.vld |=> (!st_ff.dec.vld)[*3])
        else $error("decimator output too frequent");
    chk_eq_follow: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE5
        st_ff.dec.vld |=> st_ff.eq.vld)
        else $error("equalizer missed a sample");
    chk_eq_only: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE6
        st_ff.eq.vld |-> $past(st_ff.dec.vld))
        else $error("equalizer output without input");
    chk_first_interpolator_pair: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE8
        (st_ff.eq.vld && i_kout != KOUT_RST) ##1 (i_kout != KOUT_RST)
        |-> st_ff.i1.vld ##1 st_ff.i1.vld)
        else $error("first interpolator not doubling");
    chk_second_interpolator_pair: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE9
        (st_ff.i1.vld && i_kout != KOUT_RST) ##1 (i_kout != KOUT_RST)
        |-> st_ff.i2.vld ##1 st_ff.i2.vld)
        else $error("second interpolator not doubling");
    chk_emit_space: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE10
        st_ff.emit |=> (!st_ff.emit)[*3])
        else $error("output period below four clocks");
    chk_rs_reset: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE11
        (i_kout == KOUT_RST) |=> (st_ff.rs == RS_RESET && st_ff.acc == '0))
        else $error("zero factor did not reset resampler");
    chk_no_emit_rst: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE15
        (st_ff.rs == RS_RESET) |-> !st_ff.emit)
        else $error("word emitted during resampler reset");

    // stage gating, sources and sticky loss flag
    chk_s2_half: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE1
        st_ff.s2.vld |=> (!st_ff.s2.vld)[*3])
        else $error("second sinc stage did not halve the rate");
    chk_s1_off: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE2
        (i_bw_sel != BW_5 && i_bw_sel != BW_2P5) |=> !st_ff.s1.vld)
        else $error("first sinc stage active in bypass band");
    chk_s2_off: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE3
        (i_bw_sel != BW_2P5) |=> !st_ff.s2.vld)
        else $error("second sinc stage active outside its band");
    chk_dec_phase: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE4
        st_ff.dec.vld |-> (st_ff.dec_ph == '0))
        else $error("decimator result off its phase");
    chk_eq_line: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE6
        st_ff.eq.vld |-> (st_ff.eq_line[0] == $past(st_ff.dec.smp)))
        else $error("equalizer did not take the decimator sample");
    chk_i1_src: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE8
        st_ff.i1.vld |-> ($past(st_ff.eq.vld) || $past(st_ff.i1_zero)))
        else $error("first interpolator output without source");
    chk_i2_src: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE9
        st_ff.i2.vld |-> ($past(st_ff.i1.vld) || $past(st_ff.i2_zero)))
        else $error("second interpolator output without source");
    chk_emit_run: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE10
        st_ff.emit |-> $past(i_kout != KOUT_RST))
        else $error("word emitted without a division factor");
    chk_rs_run: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE11
        (i_kout != KOUT_RST) |=> (st_ff.rs == RS_RUN))
        else $error("nonzero factor left resampler in reset");
    chk_hold_clear: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE11
        (i_kout == KOUT_RST) |=> (st_ff.hold == '0 && !st_ff.i1_zero))
        else $error("resampler state survived a zero factor");
    chk_drop_set: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE15
        (st_ff.emit && !wr_ready) |=> st_ff.drop)
        else $error("refused word did not raise the loss flag");
    chk_drop_stick: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE15
        st_ff.drop |=> st_ff.drop)
        else $error("loss flag cleared without reset");

endmodule

// *** bench/dre_receiver.sv ***
// dre_receiver: downstream model that takes result words and can stall
`timescale 1ns/1ps
module dre_receiver
    import dre_pkg::*;
(
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rstn,
    // stall request from the bench
    input  wire logic          i_stall,
    // result stream
    input  wire logic [OW-1:0] i_data,
    input  wire logic          i_valid,
    output logic               o_ready,
    // capture record
    output int                 o_taken,
    output logic      [OW-1:0] o_last
);
    // ready follows the stall request one edge late, like a slow sink
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_ready <= 1'b0;
            o_taken <= 0;
            o_last  <= '0;
        end else begin
            o_ready <= !i_stall;
            if (i_valid && o_ready) begin
                o_taken <= o_taken + 1;
                o_last  <= i_data;
            end
        end
    end
endmodule

// *** bench/dre_engine_bench.sv ***
// dre_engine_bench: self-checking bench of the decimation engine
`timescale 1ns/1ps
module dre_engine_bench;
    import dre_pkg::*;
    // =========================================================
    // stimulus and observed signals
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic          mod_bit = 1'b0;
    logic          stall = 1'b0;
    logic [1:0]    bw = BW_10;
    logic [5:0]    kout = KOUT_RST;
    logic [OW-1:0] data;
    logic          valid;
    logic          ready;
    logic          drop;
    logic [OW-1:0] last;
    int            taken;
    int            mismatches = 0;
    int            compares = 0;
    int            lat [4];

    // 10 MHz clock
    always #50 clk = ~clk;

    dre_engine dre_engine_i (.i_clk(clk), .i_rstn(rstn), .i_mod_bit(mod_bit), .i_bw_sel(bw),
        .i_kout(kout), .i_ready(ready), .o_data(data), .o_valid(valid), .o_drop(drop));
    dre_receiver dre_receiver_i (.i_clk(clk), .i_rstn(rstn), .i_stall(stall), .i_data(data),
        .i_valid(valid), .o_ready(ready), .o_taken(taken), .o_last(last));

    // =========================================================
    // shared helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // host sequence: zero the factor first, then the wanted one
    task automatic set_factor(input logic [5:0] k);
        kout <= KOUT_RST;
        cycles(2);
        kout <= k;
        cycles(1);
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        cycles(16);
        rstn <= 1'b1;
        cycles(1);
        @(negedge clk);
        check("valid", 32'(valid), 0);
        check("data", 32'(data), 0);
        check("drop", 32'(drop), 0);
    endtask

    // =========================================================
    // scenarios
    task automatic t_hold();
        int t0;
        t0 = taken;
        cycles(300);
        @(negedge clk);
        check("words in reset", 32'(taken - t0), 0);
        check("valid in reset", 32'(valid), 0);
        $display("test hold done");
    endtask

    task automatic t_rate();
        logic [5:0] codes [5] = '{6'h01, 6'h08, 6'h09, 6'h14, 6'h3f};
        int exp [5] = '{315, 315, 280, 126, 40};
        int n;
        for (int i = 0; i < 5; i++) begin
            set_factor(codes[i]);
            cycles(60);
            n = taken;
            cycles(1260);
            n = taken - n;
            check("rate", 32'(n >= exp[i] - 1 && n <= exp[i] + 1), 1);
        end
        $display("test rate done");
    endtask

    task automatic t_band();
        int n;
        for (int b = 0; b < 4; b++) begin
            bw <= 2'(b);
            mod_bit <= 1'b0;
            set_factor(6'h08);
            cycles(3000);
            @(negedge clk);
            check("low level", 32'(last), 32'(OUT_LO));
            @(posedge clk);
            mod_bit <= 1'b1;
            n = 0;
            while (last !== OUT_HI && n < 4000) begin
                cycles(1);
                n++;
            end
            if (n >= 4000) begin
                mismatches++;
                $display("Error step wait ran out");
                end_of_test();
            end
            lat[b] = n;
            check("high level", 32'(last), 32'(OUT_HI));
        end
        check("one stage slower", 32'(lat[1] > lat[0]), 1);
        check("two stages slower", 32'(lat[2] > lat[1]), 1);
        check("code 3 bypass", 32'(lat[3] - lat[0] <= 4 && lat[0] - lat[3] <= 4), 1);
        $display("test band done");
    endtask

    task automatic t_buffer();
        logic [OW-1:0] held;
        int t0;
        @(negedge clk);
        check("drop clear", 32'(drop), 0);
        @(posedge clk);
        stall <= 1'b1;
        set_factor(6'h08);
        cycles(100);
        @(negedge clk);
        check("valid held", 32'(valid), 1);
        check("drop set", 32'(drop), 1);
        held = data;
        cycles(10);
        @(negedge clk);
        check("data stands", 32'(data), 32'(held));
        @(posedge clk);
        kout <= KOUT_RST;
        cycles(4);
        t0 = taken;
        stall <= 1'b0;
        cycles(40);
        @(negedge clk);
        check("drained", 32'(taken - t0), 32'(FIFO_DEPTH + 1));
        check("empty", 32'(valid), 0);
        @(posedge clk);
        do_reset();
        $display("test buffer done");
    endtask

    // main sequence
    initial begin
        do_reset();
        t_hold();
        t_rate();
        t_band();
        t_buffer();
        end_of_test();
    end
endmodule
